/* File: logic/dtc_defines.svh */
// Register offsets, field positions, reset values and timing counts.
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH

// ==========================================================
// Register byte offsets on the Wishbone bus
`define DTC_OFF_RUN_FLAG   8'h00
`define DTC_OFF_MODE       8'h04
`define DTC_OFF_PRESCALE   8'h08
`define DTC_OFF_C0_LOW     8'h0C
`define DTC_OFF_C0_HIGH    8'h10
`define DTC_OFF_C1_LOW     8'h14
`define DTC_OFF_C1_HIGH    8'h18
`define DTC_OFF_INT_STAT   8'h1C
`define DTC_OFF_INT_CLR    8'h20
`define DTC_OFF_INT_EN     8'h24

// ==========================================================
// Field positions: run/flag register (run at 4+2n, flag at 5+2n)
`define DTC_RUN_BIT0       4
`define DTC_OVF_BIT0       5
// Mode register: channel n uses bits 4n+3..4n
`define DTC_MODE_LSB       0
`define DTC_SRC_BIT        2
`define DTC_GATE_BIT       3
`define DTC_CHAN_STRIDE    4

// ==========================================================
// Reset values and timing
`define DTC_RST_BYTE       8'h00
`define DTC_TICK_DIV       4'hC
`define DTC_TICK_LAST      4'hB

`endif

/* File: logic/dtc_pkg.sv */
// Types shared by the dual timer/counter design files.
`default_nettype none

package dtc_pkg;

  // ========================================================
  // Operating mode field encoding.
  typedef enum logic [1:0] {
    DTC_MODE_13  = 2'b00,
    DTC_MODE_16  = 2'b01,
    DTC_MODE_8R  = 2'b10,
    DTC_MODE_SPL = 2'b11
  } dtc_mode_e;

  typedef logic [7:0] dtc_byte_t;

endpackage : dtc_pkg

`default_nettype wire

/* File: logic/dtc_edge_det.sv */
// Falling-edge detector for one external event input.
`timescale 1ns/10ps
`default_nettype none

module dtc_edge_det
  import dtc_pkg::*;
(
  // Clock, reset and enable
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  // Event pin and detected edge
  input  wire logic pin_i,
  output logic      fall_o
);

  typedef struct packed {
    logic prev;
    logic fall;
  } dtc_edge_s;

  dtc_edge_s st_ff;
  dtc_edge_s nxt_st;

  // ========================================================
  // Sample the pin each clock; a high then low sample is an edge.
  // A level held two clocks is always seen, so rates up to a
  // quarter of the clock are counted without loss.
  always_comb begin
    nxt_st = st_ff;
    if (ce_i) begin
      nxt_st.prev = pin_i;
      nxt_st.fall = st_ff.prev & ~pin_i;
    end
  end

  // ========================================================
  // State register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign fall_o = st_ff.fall;

endmodule : dtc_edge_det

`default_nettype wire

/* File: logic/dtc_top.sv */
// Dual timer/counter with 13-bit, 16-bit and 8-bit reload modes.
//
// Operation
// R1 - Timer function counts ticks of clock divided by one or twelve.
// R2 - Counter function counts falling edges on the selected event pin.
// R3 - Events are sampled on the clock, rates to a quarter clock.
// R4 - External source holds each event level at least two clocks.
// R5 - Each channel has a 16-bit count seen as low and high bytes.
// R6 - Each channel has its own two-bit mode field, set independently.
// R7 - Mode 0 13-bit, 1 16-bit, 2 8-bit reload, 3 split elsewhere.
// R8 - 13-bit: high byte upper eight bits, low bits 4..0 lower five.
// R9 - 13-bit wrap to zero sets overflow flag and interrupt request.
// R10 - Source select 0 counts clock ticks, 1 counts pin falling edges.
// R11 - Count only when run is set and gate is clear or gate pin high.
// R12 - Setting the run bit leaves the count register unchanged.
// R13 - Channel 1 behaves like channel 0 with its own bits.
// R14 - 16-bit mode counts all sixteen bits, overflow on wrap to zero.
// R15 - Reload mode: low byte wraps, sets flag, reloads from high byte.
// R16 - Software loads low byte before enabling reload mode.
// R17 - Overflow flag holds until vector acknowledge or software clear.
`timescale 1ns/10ps
`default_nettype none
`include "dtc_defines.svh"

module dtc_top
  import dtc_pkg::*;
#(
  parameter int NCH = 2
)(
  // Clock, reset and clock enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // External pins
  input  wire logic [1:0]  event_pin_i,
  input  wire logic [1:0]  ext_gate_pin_i,
  // Processor vectored to a channel's interrupt
  input  wire logic [1:0]  vec_ack_i,
  // Status outputs
  output logic [1:0]       overflow_flag_o,
  output logic             irq_o
);

  // ========================================================
  // Whole module state.
  typedef struct packed {
    logic             ack;
    logic [31:0]      rdat;
    logic [1:0]       run_bit;
    logic [1:0]       overflow_flag;
    logic [1:0][1:0]  mode_field;
    logic [1:0]       source_select;
    logic [1:0]       gate_enable;
    logic [1:0]       clock_select_bits;
    dtc_byte_t [1:0]  count_low;
    dtc_byte_t [1:0]  count_high;
    logic [3:0]       pre;
    logic [1:0]       int_stat;
    logic [1:0]       int_en;
    logic             irq;
  } dtc_state_s;

  dtc_state_s st_ff;
  dtc_state_s nxt_st;

  logic [1:0] fall_w;

  // ========================================================
  // One increment step: returns {overflow, high, low}.
  function automatic logic [16:0] step(input dtc_mode_e m,
                                       input dtc_byte_t lo,
                                       input dtc_byte_t hi);
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0]  s8;
    s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    s16 = {1'b0, hi, lo} + 17'h00001;
    s8  = {1'b0, lo} + 9'h001;
    case (m)
      DTC_MODE_13: begin
        // Upper low-byte bits are don't-care; they simply hold.
        step = {s13[13], s13[12:5], lo[7:5], s13[4:0]}; // R8 R9
      end
      DTC_MODE_16: begin
        step = s16; // R14
      end
      DTC_MODE_8R: begin
        // Reload value in the high byte is never modified.
        step = {s8[8], hi, s8[8] ? hi : s8[7:0]}; // R15
      end
      default: begin
        // Split mode belongs to other logic; the channel holds.
        step = {1'b0, hi, lo}; // R7
      end
    endcase
  endfunction : step

  // ========================================================
  // Byte write helper honouring the low byte lane only.
  function automatic dtc_byte_t wbyte(input dtc_byte_t old,
                                      input logic [3:0] sel,
                                      input logic [31:0] dat);
    wbyte = sel[0] ? dat[7:0] : old;
  endfunction : wbyte

  // ========================================================
  // Edge detectors for the two event pins.
  for (genvar g = 0; g < NCH; g++) begin : g_edge
    dtc_edge_det u_edge (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .ce_i   (ce_i),
      .pin_i  (event_pin_i[g]),
      .fall_o (fall_w[g])
    ); // R3
  end

  // ========================================================
  // Next-state logic: bus, prescaler, counting, flags, interrupt.
  // Bus writes commit at the edge where ack is high, so software
  // loads take priority over a count in that same cycle.
  always_comb begin
    logic        tick12;
    logic        wr;
    logic        rd;
    logic [16:0] nx;
    logic        inc;
    logic [1:0]  ovf_ev;
    logic [31:0] rv;
    tick12 = 1'b0;
    wr     = 1'b0;
    rd     = 1'b0;
    nx     = 17'h00000;
    inc    = 1'b0;
    ovf_ev = 2'b00;
    rv     = 32'h00000000;
    nxt_st = st_ff;

    if (ce_i) begin
      // Shared divide-by-twelve tick generator.
      tick12 = (st_ff.pre == `DTC_TICK_LAST);
      nxt_st.pre = tick12 ? 4'h0 : st_ff.pre + 4'h1; // R1

      // Count both channels.
      for (int i = 0; i < NCH; i++) begin
        if (st_ff.source_select[i]) begin
          inc = fall_w[i]; // R2 R10
        end else begin
          inc = st_ff.clock_select_bits[i] | tick12; // R1 R10
        end
        // Gate pin is active high when gating is selected.
        inc = inc & st_ff.run_bit[i] &
              (~st_ff.gate_enable[i] | ext_gate_pin_i[i]); // R11
        if (inc) begin
          nx = step(dtc_mode_e'(st_ff.mode_field[i]),
                    st_ff.count_low[i], st_ff.count_high[i]); // R13
          nxt_st.count_high[i] = nx[15:8];
          nxt_st.count_low[i]  = nx[7:0];
          ovf_ev[i]            = nx[16];
        end
        // Vector acknowledge clears the flag.
        if (vec_ack_i[i]) begin
          nxt_st.overflow_flag[i] = 1'b0; // R17
        end
      end

      // Wishbone: ack one cycle after request, write at ack edge.
      nxt_st.ack = wb_cyc_i & wb_stb_i & ~st_ff.ack;
      wr = wb_cyc_i & wb_stb_i & wb_we_i & st_ff.ack;
      rd = wb_cyc_i & wb_stb_i & ~st_ff.ack;

      if (wr) begin
        case (wb_adr_i)
          `DTC_OFF_RUN_FLAG: begin
            if (wb_sel_i[0]) begin
              // Run bit writes leave the count untouched.
              for (int i = 0; i < NCH; i++) begin
                nxt_st.run_bit[i] =
                  wb_dat_i[`DTC_RUN_BIT0 + 2 * i]; // R12
                nxt_st.overflow_flag[i] =
                  wb_dat_i[`DTC_OVF_BIT0 + 2 * i]; // R17
              end
            end
          end
          `DTC_OFF_MODE: begin
            if (wb_sel_i[0]) begin
              for (int i = 0; i < NCH; i++) begin
                nxt_st.mode_field[i] = wb_dat_i[
                  `DTC_CHAN_STRIDE * i + `DTC_MODE_LSB +: 2]; // R6
                nxt_st.source_select[i] =
                  wb_dat_i[`DTC_CHAN_STRIDE * i + `DTC_SRC_BIT];
                nxt_st.gate_enable[i] =
                  wb_dat_i[`DTC_CHAN_STRIDE * i + `DTC_GATE_BIT];
              end
            end
          end
          `DTC_OFF_PRESCALE: begin
            if (wb_sel_i[0]) begin
              nxt_st.clock_select_bits = wb_dat_i[1:0]; // R1
            end
          end
          `DTC_OFF_C0_LOW: begin
            nxt_st.count_low[0] =
              wbyte(st_ff.count_low[0], wb_sel_i, wb_dat_i); // R5
          end
          `DTC_OFF_C0_HIGH: begin
            nxt_st.count_high[0] =
              wbyte(st_ff.count_high[0], wb_sel_i, wb_dat_i); // R5
          end
          `DTC_OFF_C1_LOW: begin
            nxt_st.count_low[1] =
              wbyte(st_ff.count_low[1], wb_sel_i, wb_dat_i); // R13
          end
          `DTC_OFF_C1_HIGH: begin
            nxt_st.count_high[1] =
              wbyte(st_ff.count_high[1], wb_sel_i, wb_dat_i); // R13
          end
          `DTC_OFF_INT_CLR: begin
            if (wb_sel_i[0]) begin
              nxt_st.int_stat = st_ff.int_stat & ~wb_dat_i[1:0];
            end
          end
          `DTC_OFF_INT_EN: begin
            if (wb_sel_i[0]) begin
              nxt_st.int_en = wb_dat_i[1:0];
            end
          end
          default: begin
            // Unmapped or read-only: acknowledged, no effect.
          end
        endcase
      end

      // A new overflow wins over any clear in the same cycle.
      for (int i = 0; i < NCH; i++) begin
        if (ovf_ev[i]) begin
          nxt_st.overflow_flag[i] = 1'b1; // R9 R14 R15
          nxt_st.int_stat[i]      = 1'b1;
        end
      end

      // Read data is captured in the cycle ack rises.
      if (rd && !wb_we_i) begin
        case (wb_adr_i)
          `DTC_OFF_RUN_FLAG: begin
            for (int i = 0; i < NCH; i++) begin
              rv[`DTC_RUN_BIT0 + 2 * i] = st_ff.run_bit[i];
              rv[`DTC_OVF_BIT0 + 2 * i] = st_ff.overflow_flag[i];
            end
          end
          `DTC_OFF_MODE: begin
            for (int i = 0; i < NCH; i++) begin
              rv[`DTC_CHAN_STRIDE * i + `DTC_MODE_LSB +: 2] =
                st_ff.mode_field[i];
              rv[`DTC_CHAN_STRIDE * i + `DTC_SRC_BIT] =
                st_ff.source_select[i];
              rv[`DTC_CHAN_STRIDE * i + `DTC_GATE_BIT] =
                st_ff.gate_enable[i];
            end
          end
          `DTC_OFF_PRESCALE: rv[1:0] = st_ff.clock_select_bits;
          `DTC_OFF_C0_LOW:   rv[7:0] = st_ff.count_low[0];
          `DTC_OFF_C0_HIGH:  rv[7:0] = st_ff.count_high[0];
          `DTC_OFF_C1_LOW:   rv[7:0] = st_ff.count_low[1];
          `DTC_OFF_C1_HIGH:  rv[7:0] = st_ff.count_high[1];
          `DTC_OFF_INT_STAT: rv[1:0] = st_ff.int_stat;
          `DTC_OFF_INT_EN:   rv[1:0] = st_ff.int_en;
          default:           rv      = 32'h00000000;
        endcase
        nxt_st.rdat = rv;
      end else if (rd) begin
        nxt_st.rdat = 32'h00000000;
      end

      // Level interrupt from enabled sticky status, registered.
      nxt_st.irq = |(nxt_st.int_stat & nxt_st.int_en);
    end
  end

  // ========================================================
  // State register; clock enable low freezes everything.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ========================================================
  // Outputs straight from the state register.
  assign wb_dat_o        = st_ff.rdat;
  assign wb_ack_o        = st_ff.ack;
  assign overflow_flag_o = st_ff.overflow_flag;
  assign irq_o           = st_ff.irq;

endmodule : dtc_top

`default_nettype wire

/* File: sim/dtc_top_props.sv */
// Checker of bus, flag and interrupt relations at the top ports.
`timescale 1ns/10ps
`default_nettype none

module dtc_top_props #(
  parameter int NCH = 2
)(
  // Clock, reset and enable
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       ce_i,
  // Bus handshake
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_we_i,
  input wire logic       wb_ack_o,
  // Flags and interrupt
  input wire logic [1:0] vec_ack_i,
  input wire logic [1:0] overflow_flag_o,
  input wire logic       irq_o
);
  // ==========================================================
  // Shared clocking and handshake steps.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  endsequence
  sequence s_ack;
    wb_ack_o && ce_i;
  endsequence

  // ==========================================================
  // Handshake and freeze rules; a flag may only drop on a vector acknowledge or a bus write.
  property p_ack_answer;
    s_req |=> wb_ack_o;
  endproperty
  property p_ack_pulse;
    s_ack |=> !wb_ack_o;
  endproperty
  property p_no_spurious;
    !(wb_cyc_i && wb_stb_i) && !wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_freeze;
    !ce_i |=> $stable(overflow_flag_o) && $stable(wb_ack_o);
  endproperty
  property p_flag0_hold;
    overflow_flag_o[0] && !vec_ack_i[0] && !(wb_cyc_i && wb_we_i)
      |=> overflow_flag_o[0];
  endproperty
  property p_flag1_hold;
    overflow_flag_o[1] && !vec_ack_i[1] && !(wb_cyc_i && wb_we_i)
      |=> overflow_flag_o[1];
  endproperty
  // Status can outlive a cleared flag, so a rise needs a flag or a write.
  property p_irq_cause;
    $rose(irq_o) |-> (|overflow_flag_o) || $past(wb_ack_o && wb_we_i);
  endproperty
  // Reset must win, so this one is not disabled by it.
  property p_reset;
    @(posedge clk_i) disable iff (1'b0)
      rst_i |=> overflow_flag_o == 2'b00 && !irq_o && !wb_ack_o;
  endproperty

  a_ack_answer: assert property (p_ack_answer)
    else $error("no ack one cycle after a request");
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held longer than one cycle");
  a_no_spurious: assert property (p_no_spurious)
    else $error("ack without a request");
  a_freeze: assert property (p_freeze)
    else $error("state moved while clock enable low");
  a_flag0_hold: assert property (p_flag0_hold)
    else $error("channel 0 flag dropped without a clear");
  a_flag1_hold: assert property (p_flag1_hold)
    else $error("channel 1 flag dropped without a clear");
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt without an overflow flag");
  a_reset: assert property (p_reset)
    else $error("outputs not cleared by reset");
endmodule : dtc_top_props

bind dtc_top dtc_top_props #(.NCH(NCH)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
  .vec_ack_i(vec_ack_i), .overflow_flag_o(overflow_flag_o),
  .irq_o(irq_o)
);

`default_nettype wire

/* File: sim/dtc_pin_model.sv */
// Model of the external event and gate pin drivers.
`timescale 1ns/10ps
`default_nettype none

module dtc_pin_model (
  // Clock
  input  wire logic  clk_i,
  // Pins
  output logic [1:0] event_pin_o,
  output logic [1:0] gate_pin_o
);
  // Event pins idle high so no edge is seen until a pulse.
  initial begin
    event_pin_o = 2'b11;
    gate_pin_o = 2'b00;
  end

  // ==========================================================
  // Gate pin high for exactly n sampled edges.
  task gate_open(input int ch, input int n);
    @(posedge clk_i);
    gate_pin_o[ch] <= 1'b1;
    repeat (n) @(posedge clk_i);
    gate_pin_o[ch] <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : gate_open

  // Each level held two clocks: the fastest legal event rate.
  task pulse(input int ch, input int n);
    repeat (n) begin
      @(posedge clk_i);
      event_pin_o[ch] <= 1'b0;
      repeat (2) @(posedge clk_i);
      event_pin_o[ch] <= 1'b1;
      @(posedge clk_i);
    end
    repeat (4) @(posedge clk_i);
  endtask : pulse
endmodule : dtc_pin_model

`default_nettype wire

/* File: sim/dtc_top_tb.sv */
// Self-checking testbench of the dual timer/counter.
`timescale 1ns/10ps
`default_nettype none
`include "dtc_defines.svh"

module dtc_top_tb;
  logic        clk_i, rst_i, ce, cyc, stb, we, ack, irq;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, rdat;
  logic [1:0]  ev, gate, vec, flg;
  int          mismatches, comparisons;

  // ==========================================================
  // Clock at 125 MHz.
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  dtc_top uut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .event_pin_i(ev), .ext_gate_pin_i(gate), .vec_ack_i(vec),
    .overflow_flag_o(flg), .irq_o(irq)
  );
  dtc_pin_model pm (.clk_i(clk_i), .event_pin_o(ev), .gate_pin_o(gate));

  // ==========================================================
  // Report and bus tasks.
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One classic cycle; the bound stands in for a hung slave.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h000000, d};
    sel <= 4'h1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      mismatches++;
      end_of_test();
    end
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(nm, e, q);
  endtask : rd

  // ==========================================================
  // Main sequence.
  initial begin
    mismatches = 0;
    comparisons = 0;
    {cyc, stb, we, adr, sel, dat, vec} = '0;
    ce = 1'b1;
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("flags", 8'h00, {6'h00, flg});
    rd("c0_low", `DTC_OFF_C0_LOW, 8'h00);
    rd("unmapped", 8'h30, 8'h00);
    // Gated 16-bit count, one tick per clock, through the wrap.
    wr(`DTC_OFF_PRESCALE, 8'h01);
    wr(`DTC_OFF_MODE, 8'h09);
    wr(`DTC_OFF_C0_HIGH, 8'hFF);
    wr(`DTC_OFF_C0_LOW, 8'hF0);
    wr(`DTC_OFF_RUN_FLAG, 8'h10);
    rd("c0_low", `DTC_OFF_C0_LOW, 8'hF0);
    pm.gate_open(0, 16);
    rd("c0_high", `DTC_OFF_C0_HIGH, 8'h00);
    rd("run_flag", `DTC_OFF_RUN_FLAG, 8'h30);
    vec <= 2'b01;
    @(posedge clk_i);
    vec <= 2'b00;
    @(posedge clk_i);
    chk("flags", 8'h00, {6'h00, flg});
    // Divide by twelve: 24 open clocks give two ticks.
    wr(`DTC_OFF_PRESCALE, 8'h00);
    wr(`DTC_OFF_C0_LOW, 8'h00);
    pm.gate_open(0, 24);
    rd("c0_low", `DTC_OFF_C0_LOW, 8'h02);
    // 13-bit wrap from all ones.
    wr(`DTC_OFF_PRESCALE, 8'h01);
    wr(`DTC_OFF_MODE, 8'h08);
    wr(`DTC_OFF_C0_HIGH, 8'hFF);
    wr(`DTC_OFF_C0_LOW, 8'h1E);
    pm.gate_open(0, 2);
    rd("c0_high", `DTC_OFF_C0_HIGH, 8'h00);
    rd("c0_low", `DTC_OFF_C0_LOW, 8'h00);
    chk("flags", 8'h01, {6'h00, flg});
    chk("irq", 8'h00, {7'h00, irq});
    wr(`DTC_OFF_INT_EN, 8'h01);
    @(posedge clk_i);
    chk("irq", 8'h01, {7'h00, irq});
    wr(`DTC_OFF_INT_CLR, 8'h01);
    @(posedge clk_i);
    chk("irq", 8'h00, {7'h00, irq});
    rd("int_stat", `DTC_OFF_INT_STAT, 8'h00);
    // Channel 1 reload mode counting pin edges.
    wr(`DTC_OFF_MODE, 8'h68);
    wr(`DTC_OFF_C1_HIGH, 8'hF0);
    wr(`DTC_OFF_C1_LOW, 8'hFE);
    wr(`DTC_OFF_RUN_FLAG, 8'h40);
    pm.pulse(1, 5);
    rd("c1_low", `DTC_OFF_C1_LOW, 8'hF3);
    rd("c1_high", `DTC_OFF_C1_HIGH, 8'hF0);
    chk("flags", 8'h02, {6'h00, flg});
    rd("c0_low", `DTC_OFF_C0_LOW, 8'h00);
    // Split mode holds; a low clock enable freezes edge detection.
    wr(`DTC_OFF_MODE, 8'h78);
    pm.pulse(1, 2);
    rd("c1_low", `DTC_OFF_C1_LOW, 8'hF3);
    wr(`DTC_OFF_MODE, 8'h68);
    ce <= 1'b0;
    pm.pulse(1, 2);
    ce <= 1'b1;
    rd("c1_low", `DTC_OFF_C1_LOW, 8'hF3);
    pm.pulse(1, 1);
    rd("c1_low", `DTC_OFF_C1_LOW, 8'hF4);
    end_of_test();
  end
endmodule : dtc_top_tb

`default_nettype wire
